// *** dac_readback_device.sv ***
// Device end: serial frame decode, readback shifting and status flags.
// Assumes link pins are asynchronous to clock and the host keeps sclk idle high.
`timescale 1ns/1ps
`default_nettype none
`include "dac_readback_defines.svh"

// Function
// - Read frame: flag, address, select, ignored low.
// - Host reads channel A gain with 0xA80000.
// - Next frame shifts requested register out.
// - Selects 0-3 return channel data registers.
// - Selects 4-7 return channel control registers.
// - Selects 8-11 return channel gain registers.
// - Selects 12-15 return channel offset registers.
// - Selects 16-19 return clear code registers.
// - Selects 20-23 return slew control registers.
// - Codes 24-26 return status, main, boost.
// - Status register is read-only.
// - Status-on-write shifts status during every frame.
// - Status word bit layout as fixed.
// - Boost limit also sets channel output fault.
// - User toggle follows the software register.
// - Frame check error flags last bad frame.
// - Ramp active while enabled channel still slews.
// - Over-temperature flag follows temperature monitor.
// - Output fault flags follow pin fault detectors.
// - Slew write layout: zeros, enable, rate, step.
// - No-operation frame is 0x1CE000 per address.
// - Status-on-write hides other register readback.
// - Status read clears error; fault line releases once no fault is left.
module dac_readback_device
	import dac_readback_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	dac_serial_if.device    link,
	input  wire logic [1:0] devAddr,
	input  wire logic [3:0] boostLimit,
	input  wire logic [3:0] outputFault,
	input  wire logic       overTemp,
	input  wire logic [3:0] slewBusy,
	input  wire logic       frameCheckError,
	output logic      [3:0] slewEnable,
	output logic      [15:0] statusWord
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic [2:0]   sclkPipe;
	logic [2:0]   syncPipe;
	logic [1:0]   sdinPipe;
	logic         sclkFall;
	logic         sclkRise;
	logic         frameStart;
	logic         frameEnd;
	logic         inFrame;

	// Stage zero feeds stage one only; edges come from stages one and two.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			sclkPipe <= 3'h7;
			syncPipe <= 3'h7;
			sdinPipe <= 2'h0;
		end else begin
			sclkPipe <= {sclkPipe[1:0], link.sclk};
			syncPipe <= {syncPipe[1:0], link.syncN};
			sdinPipe <= {sdinPipe[0], link.sdin};
		end
	end

	assign sclkFall   = ~sclkPipe[1] & sclkPipe[2];
	assign sclkRise   = sclkPipe[1] & ~sclkPipe[2];
	assign frameStart = ~syncPipe[1] & syncPipe[2];
	assign frameEnd   = syncPipe[1] & ~syncPipe[2];
	assign inFrame    = ~syncPipe[1];

	// ****************************************************************
	// Device address strap
	// ****************************************************************
	logic [1:0]   devAddrReg;
	logic         addrTaken;

	// The strap is caught on the first edge after reset release, not under reset.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			addrTaken  <= 1'b0;
			devAddrReg <= 2'h0;
		end else if (!addrTaken) begin
			addrTaken  <= 1'b1;
			devAddrReg <= devAddr;
		end
	end

	// ****************************************************************
	// Receive shift register
	// ****************************************************************
	frame_type    rxShift;
	logic [5:0]   bitCount;
	logic         frameOk;
	logic         isRead;
	logic [4:0]   frameSel;
	reg_word_type frameData;

	// Bits are taken on falling sclk; the count saturates so long frames are rejected.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rxShift  <= '0;
			bitCount <= 6'h00;
		end else if (frameStart) begin
			bitCount <= 6'h00;
		end else if (inFrame && sclkFall) begin
			rxShift <= {rxShift[`FRAME_BITS-2:0], sdinPipe[1]};
			if (bitCount != 6'h3f) begin
				bitCount <= bitCount + 6'h01;
			end
		end
	end

	// Only a full-length frame addressed to this device is acted on.
	assign frameOk   = frameEnd && (bitCount == 6'(`FRAME_BITS))
	                   && (rxShift[`FRAME_ADDR_HI:`FRAME_ADDR_LO] == devAddrReg);
	assign isRead    = rxShift[`FRAME_RW_BIT];
	assign frameSel  = rxShift[`FRAME_SEL_HI:`FRAME_SEL_LO];
	assign frameData = rxShift[15:0];

	// ****************************************************************
	// Register bank
	// ****************************************************************
	reg_word_type bank [0:`REG_COUNT-1];
	logic         userToggle;
	logic         statusOnWrite;
	logic         writeHit;
	logic         slewHit;

	// The status code is never a storage target and unknown codes do nothing.
	assign writeHit = frameOk && !isRead && (frameSel < 5'(`REG_COUNT))
	                  && (frameSel != `SEL_STATUS);
	assign slewHit  = (frameSel >= `SEL_SLEW) && (frameSel < `SEL_STATUS);

	// Slew writes need zeros in the top bits; don't-care bits are dropped.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				bank[i] <= `REG_RESET;
			end
		end else if (writeHit) begin
			if (!slewHit) begin
				bank[frameSel] <= frameData;
			end else if (frameData[`SLEW_ZERO_HI:`SLEW_ZERO_LO] == 3'h0) begin
				bank[frameSel] <= frameData & `SLEW_KEEP_MASK;
			end
		end
	end

	// The software register is write-only here; only its toggle bit is kept.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			userToggle <= 1'b0;
		end else if (frameOk && !isRead && frameSel == `SEL_SOFT) begin
			userToggle <= frameData[`SOFT_TOGGLE_BIT];
		end
	end

	assign statusOnWrite = bank[`SEL_MAIN][`MAIN_STATWR_BIT];

	// Per-channel slew enables drive the ramp flag and leave the block.
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : slewBits
			assign slewEnable[ch] = bank[`SEL_SLEW + ch][`SLEW_EN_BIT];
		end
	endgenerate

	// ****************************************************************
	// Status flags
	// ****************************************************************
	logic         pecReg;
	logic         statusRead;
	logic         rampActive;
	logic [3:0]   chanFault;
	reg_word_type statusNow;

	assign rampActive = |(slewBusy & slewEnable);
	assign chanFault  = outputFault | boostLimit;

	// Bit layout of the status word; bits 7..4 read as zero.
	always_comb begin
		statusNow = 16'h0000;
		statusNow[`STAT_BOOST_LSB +: 4] = boostLimit;
		statusNow[`STAT_USER_BIT]       = userToggle;
		statusNow[`STAT_PEC_BIT]        = pecReg;
		statusNow[`STAT_RAMP_BIT]       = rampActive;
		statusNow[`STAT_OTEMP_BIT]      = overTemp;
		statusNow[`STAT_FAULT_LSB +: 4] = chanFault;
	end

	// A new error in the clearing cycle wins, so no bad frame goes unreported.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			pecReg <= 1'b0;
		end else if (frameCheckError) begin
			pecReg <= 1'b1;
		end else if (statusRead) begin
			pecReg <= 1'b0;
		end
	end

	// A registered copy of the flags, driven out on the statusWord port.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			statusWord <= 16'h0000;
		end else begin
			statusWord <= statusNow;
		end
	end

	// ****************************************************************
	// Readback request and transmit shift register
	// ****************************************************************
	logic [4:0]   pendingSel;
	logic         pendingValid;
	frame_type    txShift;
	frame_type    txWord;

	// A request is consumed by the next frame; a read there re-arms it.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			pendingSel   <= 5'h00;
			pendingValid <= 1'b0;
		end else if (frameOk && isRead) begin
			pendingSel   <= frameSel;
			pendingValid <= 1'b1;
		end else if (frameStart || frameOk) begin
			pendingValid <= 1'b0;
		end
	end

	// Status-on-write takes priority, so other readback is not available then.
	always_comb begin
		txWord = '0;
		if (statusOnWrite) begin
			txWord = {3'h0, `SEL_STATUS, statusNow};
		end else if (pendingValid) begin
			if (pendingSel == `SEL_STATUS) begin
				txWord = {3'h0, pendingSel, statusNow};
			end else if (pendingSel < 5'(`REG_COUNT)) begin
				txWord = {3'h0, pendingSel, bank[pendingSel]};
			end else begin
				txWord = {3'h0, pendingSel, 16'h0000};
			end
		end
	end

	assign statusRead = frameStart
	                    && (statusOnWrite || (pendingValid && pendingSel == `SEL_STATUS));

	// Loaded as the frame opens and shifted on each rising sclk, MSB first.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			txShift <= '0;
		end else if (frameStart) begin
			txShift <= txWord;
		end else if (inFrame && sclkRise) begin
			txShift <= {txShift[`FRAME_BITS-2:0], 1'b0};
		end
	end

	assign link.sdo = txShift[`FRAME_BITS-1];

	// ****************************************************************
	// Open-drain fault line
	// ****************************************************************
	logic         faultOeNReg;

	// Released only once no channel, frame or temperature fault is left.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			faultOeNReg <= 1'b1;
		end else begin
			faultOeNReg <= ~(|chanFault | pecReg | overTemp);
		end
	end

	assign link.faultDrive = 1'b0;
	assign link.faultOeN   = faultOeNReg;

endmodule

`default_nettype wire

// *** dac_readback_defines.svh ***
// Constants shared by the serial readback device end and its host end.
// Assumes inclusion by bare name from the same folder.
`ifndef DAC_READBACK_DEFINES_SVH
`define DAC_READBACK_DEFINES_SVH

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define FRAME_BITS      24
`define FRAME_RW_BIT    23
`define FRAME_ADDR_HI   22
`define FRAME_ADDR_LO   21
`define FRAME_SEL_HI    20
`define FRAME_SEL_LO    16
`define NOOP_FRAME      24'h1ce000

// ****************************************************************
// Read select codes
// ****************************************************************
`define SEL_DATA        5'h00
`define SEL_CTRL        5'h04
`define SEL_GAIN        5'h08
`define SEL_OFFSET      5'h0c
`define SEL_CLEAR       5'h10
`define SEL_SLEW        5'h14
`define SEL_STATUS      5'h18
`define SEL_MAIN        5'h19
`define SEL_BOOST       5'h1a
`define SEL_SOFT        5'h1b
`define REG_COUNT       27
`define REG_RESET       16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define STAT_BOOST_LSB  12
`define STAT_USER_BIT   11
`define STAT_PEC_BIT    10
`define STAT_RAMP_BIT   9
`define STAT_OTEMP_BIT  8
`define STAT_FAULT_LSB  0
`define SLEW_ZERO_HI    15
`define SLEW_ZERO_LO    13
`define SLEW_EN_BIT     12
`define SLEW_RATE_HI    6
`define SLEW_RATE_LO    3
`define SLEW_STEP_HI    2
`define SLEW_STEP_LO    0
`define SLEW_KEEP_MASK  16'h107f
`define MAIN_STATWR_BIT 11
`define SOFT_TOGGLE_BIT 11

// ****************************************************************
// Host command registers and timing
// ****************************************************************
`define HOST_FRAME_OFS  12'h000
`define HOST_RX_OFS     12'h004
`define HOST_STAT_OFS   12'h008
`define HOST_BUSY_BIT   0
`define HOST_FAULT_BIT  1
`define HOST_HALF_CYC   8

`endif

// *** dac_readback_pkg.sv ***
// Types shared by both ends of the serial readback link.
// Assumes the defines header is compiled alongside.
package dac_readback_pkg;
	typedef logic [15:0] reg_word_type;
	typedef logic [23:0] frame_type;
	typedef enum logic [4:0] {
		HOST_IDLE  = 5'b00001,
		HOST_LEAD  = 5'b00010,
		HOST_LOW   = 5'b00100,
		HOST_HIGH  = 5'b01000,
		HOST_TRAIL = 5'b10000
	} host_state_type;
endpackage

// *** dac_serial_if.sv ***
// Serial link between the host end and the device end.
// Assumes a pull-up on the shared open-drain fault line.
`timescale 1ns/1ps
`default_nettype none

interface dac_serial_if;
	logic sclk;
	logic syncN;
	logic sdin;
	logic sdo;
	logic faultDrive;
	logic faultOeN;
	wire  faultN;

	// The pull-up wins whenever the device releases the fault line.
	assign faultN = faultOeN ? 1'b1 : faultDrive;

	modport device (
		input  sclk,
		input  syncN,
		input  sdin,
		output sdo,
		output faultDrive,
		output faultOeN
	);

	modport host (
		output sclk,
		output syncN,
		output sdin,
		input  sdo,
		input  faultN
	);
endinterface

`default_nettype wire

// *** dac_readback_host.sv ***
// Host end: APB command registers driving one 24-bit serial frame at a time.
// Assumes APB on the same clock and the device end on the other side of the link.
`timescale 1ns/1ps
`default_nettype none
`include "dac_readback_defines.svh"

module dac_readback_host
	import dac_readback_pkg::*;
#(
	parameter int HALF_CYCLES = `HOST_HALF_CYC
)(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	dac_serial_if.host       link
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [1:0]     sdoPipe;
	logic [1:0]     faultPipe;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			sdoPipe   <= 2'h0;
			faultPipe <= 2'h3;
		end else begin
			sdoPipe   <= {sdoPipe[0], link.sdo};
			faultPipe <= {faultPipe[0], link.faultN};
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	host_state_type state;
	frame_type      rxData;
	logic           busy;
	logic           mapped;
	logic           startReq;

	assign busy     = (state != HOST_IDLE);
	assign mapped   = (paddr == `HOST_FRAME_OFS) || (paddr == `HOST_RX_OFS)
	                  || (paddr == `HOST_STAT_OFS);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped;
	// A frame write while busy or during the idle gap is dropped.
	assign startReq = psel & penable & pwrite & (paddr == `HOST_FRAME_OFS);

	// Read data is set up in the setup cycle, so the access cycle finds it ready.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= 32'h00000000;
			if (paddr == `HOST_RX_OFS) begin
				prdata <= {8'h00, rxData};
			end else if (paddr == `HOST_STAT_OFS) begin
				prdata[`HOST_BUSY_BIT]  <= busy;
				prdata[`HOST_FAULT_BIT] <= ~faultPipe[1];
			end
		end
	end

	// ****************************************************************
	// Frame sequencer
	// ****************************************************************
	logic [15:0]    halfCount;
	logic [4:0]     bitIndex;
	frame_type      txShift;
	frame_type      rxShift;
	logic           halfDone;

	assign halfDone = (halfCount == 16'h0000);

	// Sclk idles high; the device takes sdin on falling edges and the
	// host samples sdo late in the low phase, leaving room for sync lag.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state     <= HOST_IDLE;
			halfCount <= 16'h0000;
			bitIndex  <= 5'h00;
			txShift   <= '0;
			rxShift   <= '0;
			rxData    <= '0;
			link.sclk  <= 1'b1;
			link.syncN <= 1'b1;
			link.sdin  <= 1'b0;
		end else begin
			if (!halfDone) begin
				halfCount <= halfCount - 16'h0001;
			end
			unique case (state)
				HOST_IDLE: begin
					if (startReq && halfDone) begin
						txShift    <= pwdata[23:0];
						link.sdin  <= pwdata[23];
						link.syncN <= 1'b0;
						bitIndex   <= 5'h00;
						halfCount  <= 16'(HALF_CYCLES - 1);
						state      <= HOST_LEAD;
					end
				end
				HOST_LEAD, HOST_HIGH: begin
					if (halfDone) begin
						link.sclk <= 1'b0;
						halfCount <= 16'(HALF_CYCLES - 1);
						state     <= HOST_LOW;
					end
				end
				HOST_LOW: begin
					if (halfDone) begin
						rxShift   <= {rxShift[22:0], sdoPipe[1]};
						txShift   <= {txShift[22:0], 1'b0};
						link.sdin <= txShift[22];
						link.sclk <= 1'b1;
						bitIndex  <= bitIndex + 5'h01;
						halfCount <= 16'(HALF_CYCLES - 1);
						state     <= (bitIndex == 5'd23) ? HOST_TRAIL : HOST_HIGH;
					end
				end
				HOST_TRAIL: begin
					if (halfDone) begin
						link.syncN <= 1'b1;
						rxData     <= rxShift;
						halfCount  <= 16'(HALF_CYCLES - 1);
						state      <= HOST_IDLE;
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** dac_readback_checker.sv ***
// Checker: timing of the serial link seen between the host and device ends.
// Assumes it sits beside the interface with its signals wired in by name.
`timescale 1ns/1ps
`default_nettype none
`include "dac_readback_defines.svh"

module dac_readback_checker #(
	parameter int HALF_CYCLES = `HOST_HALF_CYC
)(
	input wire logic clock,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic syncN,
	input wire logic sdin,
	input wire logic sdo,
	input wire logic faultDrive,
	input wire logic faultOeN,
	input wire logic faultN
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// ****************
	// Helper counters
	// ****************
	logic [5:0] fallCnt;
	logic [7:0] levelCnt;
	logic [7:0] highCnt;

	// Falling serial edges seen inside the current frame.
	always_ff @(posedge clock) begin
		if (!resetn || $fell(syncN)) fallCnt <= 6'h00;
		else if (!syncN && $fell(sclk)) fallCnt <= fallCnt + 6'h01;
	end

	// Cycles since sclk last moved; saturates so long idles do not wrap.
	always_ff @(posedge clock) begin
		if (!resetn || $changed(sclk)) levelCnt <= 8'h00;
		else if (levelCnt != 8'hff) levelCnt <= levelCnt + 8'h01;
	end

	// Idle time of the frame strobe; starts full so the first frame may follow reset soon.
	always_ff @(posedge clock) begin
		if (!resetn) highCnt <= 8'hff;
		else if (!syncN) highCnt <= 8'h00;
		else if (highCnt != 8'hff) highCnt <= highCnt + 8'h01;
	end

	// ****************
	// Link assertions
	// ****************
	sequence frameStart;
		$fell(syncN);
	endsequence
	sequence frameEnd;
		$rose(syncN);
	endsequence

	AST_SCLK_IDLE: assert property (syncN |-> sclk)
		else $error("sclk not high outside a frame");
	AST_FALL_IN_FRAME: assert property ($fell(sclk) |-> !syncN)
		else $error("sclk fell outside a frame");
	AST_BIT_COUNT: assert property (frameEnd |-> fallCnt == 6'd24)
		else $error("frame did not carry 24 bits");
	AST_SDIN_HOLD: assert property ($fell(sclk) |-> $stable(sdin))
		else $error("sdin moved at the sampling edge");
	AST_SDO_HOLD: assert property ($rose(sclk) && !syncN |-> $stable(sdo)[*2])
		else $error("sdo moved around the host sampling edge");
	AST_HALF_PERIOD: assert property ($rose(sclk) |-> levelCnt == HALF_CYCLES - 1)
		else $error("sclk low half has wrong length");
	AST_FRAME_GAP: assert property (frameStart |-> highCnt >= HALF_CYCLES)
		else $error("frames too close together");
	AST_TRAIL: assert property (frameEnd |-> $past(sclk) && sclk)
		else $error("frame ended with sclk low");
	AST_FAULT_PULL: assert property (!faultOeN |-> !faultDrive && !faultN)
		else $error("fault line not pulled low when enabled");
endmodule

`default_nettype wire

// *** test_dac_readback_status.sv ***
// Testbench: host and device ends joined over the serial link, driven by APB.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dac_readback_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end

module test_dac_readback_status
	import dac_readback_pkg::*;
;
	localparam int HALF = 5;
	logic         clock;
	logic         resetn;
	logic [11:0]  paddr;
	logic         psel, penable, pwrite, pready, pslverr, serr;
	logic [31:0]  pwdata, prdata, rdata;
	logic [1:0]   devAddr;
	logic [3:0]   boostLimit, outputFault, slewBusy, slewEnable;
	logic         overTemp, frameCheckError;
	reg_word_type statusWord;
	int           num_errors, checks;

	// ****************
	// Design and checker
	// ****************
	dac_serial_if link();
	dac_readback_host #(.HALF_CYCLES(HALF)) u_dac_readback_host (.clock(clock), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	dac_readback_device u_dac_readback_device (.clock(clock), .resetn(resetn), .link(link),
		.devAddr(devAddr), .boostLimit(boostLimit), .outputFault(outputFault),
		.overTemp(overTemp), .slewBusy(slewBusy), .frameCheckError(frameCheckError),
		.slewEnable(slewEnable), .statusWord(statusWord));
	dac_readback_checker #(.HALF_CYCLES(HALF)) u_dac_readback_checker (.clock(clock),
		.resetn(resetn), .sclk(link.sclk), .syncN(link.syncN), .sdin(link.sdin),
		.sdo(link.sdo), .faultDrive(link.faultDrive), .faultOeN(link.faultOeN),
		.faultN(link.faultN));

	// Free-running 100 MHz clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****************
	// Tasks
	// ****************
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Send one frame, wait for the host to go idle plus its idle gap, then fetch what came back.
	task automatic xfer(input frame_type f);
		int n;
		apb(1'b1, `HOST_FRAME_OFS, {8'h00, f});
		n = 0;
		do begin
			apb(1'b0, `HOST_STAT_OFS, 32'h0);
			n++;
		end while (rdata[`HOST_BUSY_BIT] !== 1'b0 && n < 400);
		// A host that never goes idle is a failure, not a reason to carry on quietly.
		if (rdata[`HOST_BUSY_BIT] !== 1'b0) begin
			num_errors++;
			$display("ERROR host busy exp 0 got 1");
		end
		repeat (HALF + 2) @(posedge clock);
		apb(1'b0, `HOST_RX_OFS, 32'h0);
	endtask

	task automatic xchk(input frame_type f, input frame_type e, input string n);
		xfer(f);
		`CHK(n, e, rdata[23:0])
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Cuts a hang short; the full run needs about 20,000 cycles, so 50,000 is ample.
	initial begin
		#500000;
		num_errors++;
		final_report();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		int j;
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		devAddr = 2'b01;
		{boostLimit, outputFault, slewBusy, overTemp, frameCheckError} = '0;
		num_errors = 0;
		checks = 0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		// Fill codes 0..23, then read them back with each read chained to the next.
		for (int i = 0; i < 24; i++) xfer({3'b001, i[4:0], 16'h1a00 + 16'(i)});
		xfer(24'ha00000);
		for (int i = 1; i <= 24; i++) begin
			j = i - 1;
			xchk(i < 24 ? {3'b101, i[4:0], 16'hffff} : 24'h3ce000,
				{3'b000, j[4:0], (j >= 20 ? 16'h1000 : 16'h1a00) + 16'(j)}, "sweep");
		end
		xfer(24'ha80000);
		xchk(24'h3ce000, 24'h081a08, "gain a");
		$display("test readback done");
		// A slew write with nonzero top bits is dropped; another address is not answered.
		xfer(24'h343fff);
		xfer(24'hb40000);
		xchk(24'h3ce000, 24'h141014, "slew guard");
		`CHK("slew enable", 4'hf, slewEnable)
		xfer(24'hc80000);
		xchk(24'h3ce000, 24'h000000, "other address");
		$display("test guards done");
		// Status flags, a refused status write, and clearing of the frame error on read.
		xfer(24'h3b0800);
		boostLimit <= 4'b1000;
		outputFault <= 4'b0010;
		overTemp <= 1'b1;
		slewBusy <= 4'b0100;
		frameCheckError <= 1'b1;
		@(posedge clock);
		frameCheckError <= 1'b0;
		xfer(24'h38ffff);
		xfer(24'hb80000);
		xchk(24'h3ce000, 24'h188f0a, "status");
		apb(1'b0, `HOST_STAT_OFS, 32'h0);
		`CHK("fault low", 1'b1, rdata[`HOST_FAULT_BIT])
		xfer(24'hb80000);
		xchk(24'h3ce000, 24'h188b0a, "status again");
		`CHK("status port", 16'h8b0a, statusWord)
		{boostLimit, outputFault, slewBusy} <= '0;
		overTemp <= 1'b0;
		xfer(24'h3b0000);
		apb(1'b0, `HOST_STAT_OFS, 32'h0);
		`CHK("fault released", 1'b0, rdata[`HOST_FAULT_BIT])
		`CHK("status clear", 16'h0000, statusWord)
		$display("test status done");
		// Status returned on every frame while enabled, hiding ordinary readback.
		overTemp <= 1'b1;
		xfer(24'h390800);
		xchk(24'h281234, 24'h180100, "status on write");
		xfer(24'ha80000);
		xchk(24'h3ce000, 24'h180100, "readback hidden");
		xfer(24'h390000);
		overTemp <= 1'b0;
		xfer(24'ha80000);
		xchk(24'h3ce000, 24'h081234, "readback back");
		// Main and boost control codes, read back to back.
		xfer(24'h3a1234);
		xfer(24'hb90000);
		xchk(24'hba0000, 24'h190000, "main control");
		xchk(24'h3ce000, 24'h1a1234, "boost control");
		$display("test status on write done");
		// An unmapped host register answers with an error and zero data.
		apb(1'b0, 12'h00c, 32'h0);
		`CHK("slave error", 1'b1, serr)
		`CHK("unmapped data", 32'h0, rdata)
		$display("test unmapped done");
		final_report();
	end
endmodule

`default_nettype wire
